// ### verilog/nip_consts.svh
// Purpose: Constants of the nested priority interrupt controller
// Assumes: 100 MHz CLK, APB register access with 32-bit data
// Notes:   Offsets are byte addresses; hardware slot h sits at vector FFE0h + 2*h
//
// How it works
// - Sixteen fixed vector slots, four software levels, reset, trap and top-level are non-maskable.
// - Vectors fill FFE0h to FFFFh, a higher address meaning higher hardware priority.
// - Any reset loads the program counter from the vector at FFFEh and FFFFh.
// - Current software priority sits in condition code bits 5 and 3.
// - Levels encode as 10, 01, 00 and 11; level 3 disables maskable requests.
// - A request is taken only when the running instruction has finished.
// - Entry pushes program counter, X, accumulator and condition code onto the stack.
// - A maskable entry loads the priority bits from the serviced vector's own priority field.
// - After stacking the vector is loaded and the routine's first fetch follows.
// - Return from interrupt restores the stacked priority bits and the previous level.
// - Highest software level wins, ties go to the higher hardware slot.
// - An edge, trap or top-level request not taken stays latched until it becomes the winner.
// - Reset, trap and top-level rank above every software level in arbitration.
// - Non-maskable sources ignore the mask, stack (not reset) and enter at level 3.
// - Every non-maskable source wakes the processor from halt.
// - The top-level interrupt is raised on its selected edge of its pin.
// - Trap instruction raises a trap handled like top-level, which may preempt it.
// - After reset the first routine runs at level 3 with top hardware priority.
// - A maskable request needs its enable and a level above the current one.
// - External pin requests wake the processor from halt.
// - An external edge is latched and that latch clears on entry to its routine.
// - Enabled pins sharing a line are NANDed before detection.
// - Sense field 00 falling plus low level, 01 rising, 10 falling, 11 both.
// - A peripheral requests only while its flag and its enable are both set.
// - Writing level 0 into a priority field is ignored and the old value kept.
// - Hardware order rises from main through peripherals 8 to 0, groups 3 to 0, then top-level.
`ifndef NIP_CONSTS_SVH
`define NIP_CONSTS_SVH
`define NIP_OFF_SPR0     8'h00
`define NIP_OFF_SPR1     8'h04
`define NIP_OFF_SPR2     8'h08
`define NIP_OFF_SPR3     8'h0C
`define NIP_OFF_EXT_EN   8'h10
`define NIP_OFF_SENSE    8'h14
`define NIP_OFF_STATUS   8'h18
`define NIP_SPR_RST      8'hFF
`define NIP_SPR3_RO      4'hF
`define NIP_EXT_EN_RST   12'h000
`define NIP_SENSE_RST    8'h00
`define NIP_TLI_SEL_BIT  16
`define NIP_VEC_BASE_HI  11'h7FF
`define NIP_H_RESET      4'hF
`define NIP_H_TRAP       4'hE
`define NIP_H_TLI        4'hD
`define NIP_NUM_MASK     14
`define NIP_EXT_GROUPS   4
`define NIP_PINS_PER_GRP 3
`define NIP_NUM_PIN      12
`define NIP_NUM_PERIPH   9
`define NIP_FIRST_PERIPH 5
`define NIP_PRIO_L0      2'b10
`define NIP_PRIO_L1      2'b01
`define NIP_PRIO_L2      2'b00
`define NIP_PRIO_L3      2'b11
`define NIP_LVL_NM       3'd4
`define NIP_CC_HI_BIT    5
`define NIP_CC_LO_BIT    3
`define NIP_SENSE_LOWFALL 2'b00
`define NIP_SENSE_RISE   2'b01
`define NIP_SENSE_FALL   2'b10
`define NIP_SENSE_BOTH   2'b11
`define NIP_STACK_LAST   3'd4
`endif

// ### verilog/nip_pkg.sv
// Purpose: Types of the nested priority interrupt controller
// Assumes: Constants come from nip_consts.svh
// Notes:   One-hot sequencer states
package nip_pkg;
  typedef enum logic [2:0] {
    NIP_IDLE  = 3'b001,
    NIP_STACK = 3'b010,
    NIP_VECT  = 3'b100
  } nip_state_t;
  typedef logic [1:0] nip_prio_t;
endpackage : nip_pkg

// ### verilog/nip_sync.sv
// Purpose: Three-stage pin synchroniser with agreement filter
// Assumes: Input is asynchronous to CLK
// Notes:   Output moves only once stages two and three agree
`timescale 1ns/10ps
module nip_sync #(
  parameter logic RST_VAL = 1'b1
) (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic pin,
  output logic      sync_out
);
  logic s1_q, s2_q, s3_q, out_q;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s1_q  <= RST_VAL;
      s2_q  <= RST_VAL;
      s3_q  <= RST_VAL;
      out_q <= RST_VAL;
    end else begin
      s1_q  <= pin;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      out_q <= (s2_q == s3_q) ? s3_q : out_q;
    end
  end
  assign sync_out = out_q;
endmodule : nip_sync

// ### verilog/nip_ext_group.sv
// Purpose: One external interrupt line shared by a group of pins
// Assumes: Sense code as in nip_consts.svh
// Notes:   Set wins over the entry clear so a fresh edge is never lost
`timescale 1ns/10ps
`include "nip_consts.svh"
module nip_ext_group #(
  parameter int W = 3
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] pins,
  input  wire logic [W-1:0] en,
  input  wire logic [1:0]   sense,
  input  wire logic         clr,
  output logic              req
);
  logic [W-1:0] s;
  logic         line, prev_q, pend_q, fall, rise, hit, any_en;
  for (genvar i = 0; i < W; i++) begin : g_sync
    nip_sync #(.RST_VAL(1'b1)) u_sync (.clk(clk), .rst_b(rst_b), .pin(pins[i]), .sync_out(s[i]));
  end
  assign any_en = |en;
  // Disabled pins count as high so they never pull the NAND
  assign line = any_en & ~&(s | ~en);
  assign fall = prev_q & ~line;
  assign rise = ~prev_q & line;
  assign hit  = (sense == `NIP_SENSE_RISE) ? rise :
                (sense == `NIP_SENSE_BOTH) ? (rise | fall) : fall;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      prev_q <= 1'b0;
      pend_q <= 1'b0;
    end else begin
      prev_q <= line;
      pend_q <= hit | (pend_q & ~clr);
    end
  end
  assign req = pend_q | ((sense == `NIP_SENSE_LOWFALL) & any_en & ~line);
endmodule : nip_ext_group

// ### verilog/nip_ctrl.sv
// Purpose: Nested priority interrupt controller beside an 8-bit CPU core
// Assumes: CPU pulses INSN_END at each instruction boundary and writes
//          its stacked bytes while STACK_STB is high, one per cycle
// Notes:   APB slave answers with zero wait states
//
// The register offsets and the APB register port were decided locally.
`timescale 1ns/10ps
`include "nip_consts.svh"
module nip_ctrl (
  // Clock and reset
  input  wire logic        CLK,
  input  wire logic        RST_B,
  // APB slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // CPU pipeline side
  input  wire logic        INSN_END,
  input  wire logic        TRAP_EXEC,
  input  wire logic        HALT_MODE,
  input  wire logic        CC_WE,
  input  wire logic [7:0]  CC_WDATA,
  output logic             BUSY,
  output logic             STACK_STB,
  output logic      [2:0]  STACK_SEL,
  output logic             VEC_LOAD,
  output logic      [15:0] VEC_ADDR,
  output logic             PRIO_BIT_HI,
  output logic             PRIO_BIT_LO,
  output logic             WAKE,
  // Interrupt sources
  input  wire logic [11:0] EXT_PIN,
  input  wire logic        TOP_LEVEL_IRQ,
  input  wire logic [8:0]  PERIPH_FLAG,
  input  wire logic [8:0]  PERIPH_EN
);
  nip_pkg::nip_state_t state_q;
  logic [7:0]  spr_q [0:3];
  logic [7:0]  spr_wr [0:3];
  logic [11:0] ext_en_q;
  logic        tli_rise_q;
  logic [7:0]  sense_q;
  logic [31:0] prdata_q;
  logic [3:0]  h_q;
  logic [2:0]  step_q;
  logic [1:0]  prio_q, prio_new_q;
  logic        tli_pend_q, trap_pend_q, wake_q;
  logic        tli_s, tli_prev_q;
  logic [1:0]  spr_fld [0:13];
  logic [3:0]  ext_req;
  logic [13:0] mreq;
  logic [14:0] req_h;
  logic [2:0]  cur_lvl, cand_lvl, best_lvl;
  logic [3:0]  best_h;
  logic        best_valid;

  function automatic logic [2:0] lvl_of(input logic [1:0] b);
    case (b)
      `NIP_PRIO_L0: lvl_of = 3'd0;
      `NIP_PRIO_L1: lvl_of = 3'd1;
      `NIP_PRIO_L2: lvl_of = 3'd2;
      default:      lvl_of = 3'd3;
    endcase
  endfunction : lvl_of

  // Register decode
  wire apb_wr    = PSEL & PENABLE & PWRITE;
  wire apb_setup = PSEL & ~PENABLE;
  wire sel_spr   = (PADDR[7:4] == 4'h0) & (PADDR[1:0] == 2'b00);
  wire sel_en    = PADDR == `NIP_OFF_EXT_EN;
  wire sel_sense = PADDR == `NIP_OFF_SENSE;
  wire sel_stat  = PADDR == `NIP_OFF_STATUS;
  wire addr_hit  = sel_spr | sel_en | sel_sense | sel_stat;
  wire [1:0] spr_idx = PADDR[3:2];

  assign PREADY  = 1'b1;
  assign PSLVERR = PSEL & PENABLE & ~addr_hit;
  assign PRDATA  = prdata_q;

  // Priority fields: a write of level 0 keeps the old field
  always_comb begin
    for (int r = 0; r < 4; r++) begin
      for (int f = 0; f < 4; f++) begin
        spr_wr[r][2*f +: 2] = (PWDATA[2*f +: 2] == `NIP_PRIO_L0) ? spr_q[r][2*f +: 2]
                                                                 : PWDATA[2*f +: 2];
      end
    end
    spr_wr[3][7:4] = `NIP_SPR3_RO;
  end

  always_comb begin
    for (int m = 0; m < `NIP_NUM_MASK; m++) begin
      spr_fld[m] = spr_q[m / 4][2 * (m % 4) +: 2];
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      for (int r = 0; r < 4; r++) begin
        spr_q[r] <= `NIP_SPR_RST;
      end
      ext_en_q   <= `NIP_EXT_EN_RST;
      tli_rise_q <= 1'b0;
      sense_q    <= `NIP_SENSE_RST;
    end else if (apb_wr) begin
      if (sel_spr) begin
        spr_q[spr_idx] <= spr_wr[spr_idx];
      end
      if (sel_en) begin
        ext_en_q   <= PWDATA[11:0];
        tli_rise_q <= PWDATA[`NIP_TLI_SEL_BIT];
      end
      if (sel_sense) begin
        sense_q <= PWDATA[7:0];
      end
    end
  end

  // Read data is captured in the setup cycle, shown in the access cycle
  wire [31:0] rd_mux = sel_spr   ? {24'h00_0000, spr_q[spr_idx]} :
                       sel_en    ? {15'h0000, tli_rise_q, 4'h0, ext_en_q} :
                       sel_sense ? {24'h00_0000, sense_q} :
                       sel_stat  ? {13'h0000, BUSY, prio_q, tli_pend_q, trap_pend_q, mreq} :
                                   32'h0000_0000;
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      prdata_q <= 32'h0000_0000;
    end else if (apb_setup) begin
      prdata_q <= rd_mux;
    end
  end

  // External groups, group 0 on the highest maskable slot
  for (genvar g = 0; g < `NIP_EXT_GROUPS; g++) begin : g_ext
    nip_ext_group #(.W(`NIP_PINS_PER_GRP)) u_grp (
      .clk   (CLK),
      .rst_b (RST_B),
      .pins  (EXT_PIN[g*`NIP_PINS_PER_GRP +: `NIP_PINS_PER_GRP]),
      .en    (ext_en_q[g*`NIP_PINS_PER_GRP +: `NIP_PINS_PER_GRP]),
      .sense (sense_q[2*g +: 2]),
      .clr   (VEC_LOAD && (h_q == 4'(12 - g))),
      .req   (ext_req[g])
    );
  end

  nip_sync #(.RST_VAL(1'b0)) u_tli_sync (.clk(CLK), .rst_b(RST_B), .pin(TOP_LEVEL_IRQ), .sync_out(tli_s));
  wire tli_edge = tli_rise_q ? (tli_s & ~tli_prev_q) : (~tli_s & tli_prev_q);

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      tli_prev_q  <= 1'b0;
      tli_pend_q  <= 1'b0;
      trap_pend_q <= 1'b0;
      wake_q      <= 1'b0;
    end else begin
      tli_prev_q  <= tli_s;
      tli_pend_q  <= tli_edge | (tli_pend_q & ~(VEC_LOAD && h_q == `NIP_H_TLI));
      trap_pend_q <= TRAP_EXEC | (trap_pend_q & ~(VEC_LOAD && h_q == `NIP_H_TRAP));
      wake_q      <= HALT_MODE & (tli_pend_q | trap_pend_q | (|ext_req));
    end
  end

  // Request per maskable vector index, then per hardware slot
  always_comb begin
    mreq = 14'h0000;
    for (int m = 1; m <= `NIP_EXT_GROUPS; m++) begin
      mreq[m] = ext_req[m-1];
    end
    for (int m = `NIP_FIRST_PERIPH; m < `NIP_NUM_MASK; m++) begin
      mreq[m] = PERIPH_FLAG[m - `NIP_FIRST_PERIPH] & PERIPH_EN[m - `NIP_FIRST_PERIPH];
    end
  end

  // Slot 0 is index 13; leaving it out would shift trap and top-level down a slot
  assign req_h = {trap_pend_q, tli_pend_q, mreq[1], mreq[2], mreq[3], mreq[4], mreq[5], mreq[6],
                  mreq[7], mreq[8], mreq[9], mreq[10], mreq[11], mreq[12], mreq[13]};
  assign cur_lvl = lvl_of(prio_q);

  // Scan upward so an equal level on a higher slot takes over
  always_comb begin
    best_valid = 1'b0;
    best_h     = 4'h0;
    best_lvl   = 3'd0;
    cand_lvl   = 3'd0;
    for (int h = 0; h < 15; h++) begin
      cand_lvl = (h >= 13) ? `NIP_LVL_NM : lvl_of(spr_fld[13 - h]);
      if (req_h[h] && (h >= 13 || cand_lvl > cur_lvl) && cand_lvl >= best_lvl) begin
        best_valid = 1'b1;
        best_h     = 4'(h);
        best_lvl   = cand_lvl;
      end
    end
  end

  // Entry sequencer; reset drops straight into the vector load
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      state_q    <= nip_pkg::NIP_VECT;
      h_q        <= `NIP_H_RESET;
      prio_new_q <= `NIP_PRIO_L3;
      step_q     <= 3'd0;
    end else begin
      case (state_q)
        nip_pkg::NIP_IDLE: begin
          if (INSN_END && best_valid) begin
            state_q    <= nip_pkg::NIP_STACK;
            h_q        <= best_h;
            prio_new_q <= (best_h >= `NIP_H_TLI) ? `NIP_PRIO_L3 : spr_fld[13 - best_h];
            step_q     <= 3'd0;
          end
        end
        nip_pkg::NIP_STACK: begin
          step_q <= step_q + 3'd1;
          if (step_q == `NIP_STACK_LAST) begin
            state_q <= nip_pkg::NIP_VECT;
          end
        end
        nip_pkg::NIP_VECT: begin
          state_q <= nip_pkg::NIP_IDLE;
        end
        default: begin
          state_q <= nip_pkg::NIP_IDLE;
        end
      endcase
    end
  end

  // Entry load wins; the CPU is stalled then, so no restore is dropped
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      prio_q <= `NIP_PRIO_L3;
    end else if (state_q == nip_pkg::NIP_VECT) begin
      prio_q <= prio_new_q;
    end else if (CC_WE) begin
      prio_q <= {CC_WDATA[`NIP_CC_HI_BIT], CC_WDATA[`NIP_CC_LO_BIT]};
    end
  end

  assign BUSY        = state_q != nip_pkg::NIP_IDLE;
  assign STACK_STB   = state_q == nip_pkg::NIP_STACK;
  assign STACK_SEL   = step_q;
  assign VEC_LOAD    = state_q == nip_pkg::NIP_VECT;
  assign VEC_ADDR    = {`NIP_VEC_BASE_HI, h_q, 1'b0};
  assign PRIO_BIT_HI = prio_q[1];
  assign PRIO_BIT_LO = prio_q[0];
  assign WAKE        = wake_q;

  // Checks
  logic [1:0] prev_spr0_f0;
  always_ff @(posedge CLK) begin
    prev_spr0_f0 <= spr_q[0][1:0];
  end

  sequence s_stack;
    STACK_STB && STACK_SEL == 3'd0 ##1 STACK_STB && STACK_SEL == 3'd1 ##1
    STACK_STB && STACK_SEL == 3'd2 ##1 STACK_STB && STACK_SEL == 3'd3 ##1
    STACK_STB && STACK_SEL == 3'd4;
  endsequence
  sequence s_entry;
    state_q == nip_pkg::NIP_IDLE && INSN_END && best_valid;
  endsequence

  a_reset_vector: assert property (@(posedge CLK) $rose(RST_B) |->
    VEC_LOAD && VEC_ADDR == 16'hFFFE ##1 {PRIO_BIT_HI, PRIO_BIT_LO} == 2'b11)
    else $error("reset vector or level wrong");
  a_entry_stack: assert property (@(posedge CLK) disable iff (!RST_B)
    s_entry |=> s_stack ##1 VEC_LOAD)
    else $error("stacking sequence wrong");
  a_boundary_only: assert property (@(posedge CLK) disable iff (!RST_B)
    state_q == nip_pkg::NIP_IDLE && !INSN_END |=> !BUSY)
    else $error("entry off an instruction boundary");
  a_prio_load: assert property (@(posedge CLK) disable iff (!RST_B)
    VEC_LOAD && h_q < `NIP_H_TLI |=> {PRIO_BIT_HI, PRIO_BIT_LO} == spr_fld[13 - $past(h_q)])
    else $error("priority not loaded from vector field");
  a_nm_level3: assert property (@(posedge CLK) disable iff (!RST_B)
    VEC_LOAD && h_q >= `NIP_H_TLI |=> {PRIO_BIT_HI, PRIO_BIT_LO} == 2'b11)
    else $error("non-maskable entry not at level 3");
  a_cc_restore: assert property (@(posedge CLK) disable iff (!RST_B)
    CC_WE && !VEC_LOAD |=> {PRIO_BIT_HI, PRIO_BIT_LO} == {$past(CC_WDATA[5]), $past(CC_WDATA[3])})
    else $error("priority bits not restored");
  a_mask_level: assert property (@(posedge CLK) disable iff (!RST_B)
    (s_entry and best_h < `NIP_H_TLI) |-> lvl_of(spr_fld[13 - best_h]) > cur_lvl)
    else $error("maskable taken at or below current level");
  a_nm_ignores_mask: assert property (@(posedge CLK) disable iff (!RST_B)
    state_q == nip_pkg::NIP_IDLE && INSN_END && tli_pend_q |=> BUSY && h_q >= `NIP_H_TLI)
    else $error("top-level or trap not taken");
  a_lvl0_write: assert property (@(posedge CLK) disable iff (!RST_B)
    apb_wr && PADDR == `NIP_OFF_SPR0 && PWDATA[1:0] == 2'b10 |=> spr_q[0][1:0] == prev_spr0_f0)
    else $error("level 0 written into a priority field");
  a_wake_halt: assert property (@(posedge CLK) disable iff (!RST_B)
    HALT_MODE && (tli_pend_q || (|ext_req)) |=> WAKE)
    else $error("halt not left on wake source");
  a_unmapped_err: assert property (@(posedge CLK) disable iff (!RST_B)
    PSEL && PENABLE && PADDR == 8'h1C |-> PSLVERR && PREADY)
    else $error("unmapped access not flagged");
endmodule : nip_ctrl

// ### tb/nip_cpu_model.sv
// Purpose: CPU core stand-in that ends instructions and takes stacked bytes
// Assumes: The controller starts an entry only on an INSN_END pulse
// Notes:   Stacking faults are counted in seq_err for the bench to read
`timescale 1ns/10ps
module nip_cpu_model (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // Controller side
  input  wire logic       busy,
  input  wire logic       stack_stb,
  input  wire logic [2:0] stack_sel,
  output logic            insn_end,
  output logic            trap_exec,
  output logic            cc_we,
  output logic [7:0]      cc_wdata
);
  logic       run = 1'b1;
  int         gap = 1;
  int         cnt = 0;
  int         seq_err = 0;
  logic [2:0] nxt_q = 3'h0;
  logic       ie_q = 1'b0;
  initial begin
    insn_end = 1'b0;
    trap_exec = 1'b0;
    cc_we = 1'b0;
    cc_wdata = 8'h28;
  end
  // A halted core ends no instruction; a slow one ends one every gap+1 cycles
  always @(posedge clk) begin
    ie_q <= insn_end;
    cnt <= (cnt >= gap) ? 0 : cnt + 1;
    insn_end <= rst_b && run && !busy && (cnt == gap);
    if (stack_stb) begin
      if (stack_sel !== nxt_q || (stack_sel == 3'h0 && !ie_q)) seq_err++;
      nxt_q <= (stack_sel == 3'h4) ? 3'h0 : stack_sel + 3'h1;
    end else if (nxt_q != 3'h0) begin
      seq_err++;
      nxt_q <= 3'h0;
    end
  end
  // Stands in for the return instruction popping the saved condition code
  task automatic return_from_irq(input logic [7:0] cc);
    @(posedge clk);
    cc_we <= 1'b1;
    cc_wdata <= cc;
    @(posedge clk);
    cc_we <= 1'b0;
  endtask : return_from_irq
  task automatic trap();
    @(posedge clk);
    trap_exec <= 1'b1;
    @(posedge clk);
    trap_exec <= 1'b0;
  endtask : trap
endmodule : nip_cpu_model

// ### tb/nip_ctrl_tb.sv
// Purpose: Self-checking bench for the nested priority interrupt controller
// Assumes: nip_cpu_model plays the CPU pipeline side
// Notes:   Priority fields set in t_regs and t_periph carry over to later scenarios
`timescale 1ns/10ps
`include "nip_consts.svh"
module nip_ctrl_tb;
  logic        clk = 1'b0;
  logic        rst_b;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        insn_end;
  logic        trap_exec;
  logic        halt_mode;
  logic        cc_we;
  logic [7:0]  cc_wdata;
  logic        busy;
  logic        stack_stb;
  logic [2:0]  stack_sel;
  logic        vec_load;
  logic [15:0] vec_addr;
  logic        prio_hi;
  logic        prio_lo;
  logic        wake;
  logic [11:0] ext_pin;
  logic        top_level_irq;
  logic [8:0]  pflag;
  logic [8:0]  pen;
  logic [31:0] rd;
  logic        er;
  int          fail_count = 0;
  int          samples_checked = 0;

  always #5 clk = ~clk;

  nip_ctrl DUT (
    .CLK(clk), .RST_B(rst_b), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .INSN_END(insn_end), .TRAP_EXEC(trap_exec), .HALT_MODE(halt_mode), .CC_WE(cc_we),
    .CC_WDATA(cc_wdata), .BUSY(busy), .STACK_STB(stack_stb), .STACK_SEL(stack_sel),
    .VEC_LOAD(vec_load), .VEC_ADDR(vec_addr), .PRIO_BIT_HI(prio_hi), .PRIO_BIT_LO(prio_lo),
    .WAKE(wake), .EXT_PIN(ext_pin), .TOP_LEVEL_IRQ(top_level_irq), .PERIPH_FLAG(pflag), .PERIPH_EN(pen)
  );
  nip_cpu_model cpu (
    .clk(clk), .rst_b(rst_b), .busy(busy), .stack_stb(stack_stb), .stack_sel(stack_sel),
    .insn_end(insn_end), .trap_exec(trap_exec), .cc_we(cc_we), .cc_wdata(cc_wdata)
  );

  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  function automatic logic [31:0] pb();
    return {30'h0, prio_hi, prio_lo};
  endfunction : pb
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) fail_count++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic entry(input logic [15:0] v, input logic [1:0] p);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (vec_load !== 1'b1 && n < 200);
    chk("vector", {16'h0000, vec_addr}, {16'h0000, v});
    repeat (2) @(posedge clk);
    #1;
    chk("prio bits", pb(), {30'h0, p});
  endtask : entry
  task automatic quiet(input int cyc);
    int c;
    c = 0;
    repeat (cyc) begin
      @(posedge clk);
      #1;
      if (vec_load === 1'b1) c++;
    end
    chk("no entry", c, 0);
  endtask : quiet

  task automatic t_reset();
    chk("reset load", {31'h0, vec_load}, 32'h0000_0001);
    chk("reset vector", {16'h0000, vec_addr}, 32'h0000_FFFE);
    chk("reset level", pb(), {30'h0, `NIP_PRIO_L3});
    apb(1'b0, `NIP_OFF_STATUS, 32'h0000_0000);
    chk("status level", {30'h0, rd[17:16]}, 32'h0000_0003);
    cpu.return_from_irq(8'h20);
    repeat (2) @(posedge clk);
    #1;
    chk("main level", pb(), {30'h0, `NIP_PRIO_L0});
    $display("test reset done");
  endtask : t_reset
  task automatic t_regs();
    apb(1'b1, `NIP_OFF_SPR0, 32'h0000_00CF);
    apb(1'b1, `NIP_OFF_SPR0, 32'h0000_0064);
    apb(1'b0, `NIP_OFF_SPR0, 32'h0000_0000);
    chk("level 0 write", rd, 32'h0000_0044);
    apb(1'b1, `NIP_OFF_SPR3, 32'h0000_0000);
    apb(1'b0, `NIP_OFF_SPR3, 32'h0000_0000);
    chk("upper nibble", rd, 32'h0000_00F0);
    apb(1'b1, 8'h1C, 32'h0000_00FF);
    chk("unmapped error", {31'h0, er}, 32'h0000_0001);
    $display("test registers done");
  endtask : t_regs
  // Slow core: a level 2 peripheral beats a level 1 one with higher slot
  task automatic t_periph();
    cpu.gap = 7;
    apb(1'b1, `NIP_OFF_SPR1, 32'h0000_00C7);
    pflag <= 9'h001;
    quiet(20);
    pflag <= 9'h003;
    pen <= 9'h003;
    entry(16'hFFEE, `NIP_PRIO_L2);
    pflag <= 9'h001;
    quiet(30);
    cpu.return_from_irq(8'h20);
    entry(16'hFFF0, `NIP_PRIO_L1);
    pflag <= 9'h000;
    cpu.return_from_irq(8'h20);
    apb(1'b1, `NIP_OFF_SPR1, 32'h0000_00D7);
    pflag <= 9'h003;
    entry(16'hFFF0, `NIP_PRIO_L1);
    pflag <= 9'h002;
    quiet(20);
    cpu.return_from_irq(8'h20);
    entry(16'hFFEE, `NIP_PRIO_L1);
    pflag <= 9'h000;
    cpu.return_from_irq(8'h20);
    cpu.gap = 1;
    $display("test peripherals done");
  endtask : t_periph
  task automatic t_nmi();
    cpu.return_from_irq(8'h28);
    pflag <= 9'h001;
    quiet(20);
    cpu.run = 1'b0;
    halt_mode <= 1'b1;
    top_level_irq <= 1'b0;
    repeat (12) @(posedge clk);
    #1;
    chk("wake", {31'h0, wake}, 32'h0000_0001);
    cpu.run = 1'b1;
    halt_mode <= 1'b0;
    entry(16'hFFFA, `NIP_PRIO_L3);
    cpu.trap();
    entry(16'hFFFC, `NIP_PRIO_L3);
    pflag <= 9'h000;
    top_level_irq <= 1'b1;
    cpu.return_from_irq(8'h20);
    quiet(20);
    $display("test non-maskable done");
  endtask : t_nmi
  // Group 0 pins all enabled and idle high, so the shared line sits low
  task automatic t_ext();
    logic [1:0] code [5] = '{2'b01, 2'b10, 2'b11, 2'b11, 2'b00};
    logic       pv [5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
    // Rising sense first: the reset level mode would request as soon as the pins are enabled
    apb(1'b1, `NIP_OFF_SENSE, 32'h0000_0001);
    apb(1'b1, `NIP_OFF_EXT_EN, 32'h0000_0007);
    cpu.run = 1'b0;
    halt_mode <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, `NIP_OFF_SENSE, {30'h0, code[i]});
      ext_pin[0] <= pv[i];
      if (i == 0) begin
        repeat (12) @(posedge clk);
        #1;
        chk("ext wake", {31'h0, wake}, 32'h0000_0001);
        cpu.run = 1'b1;
        halt_mode <= 1'b0;
      end
      entry(16'hFFF8, `NIP_PRIO_L1);
      cpu.return_from_irq(8'h20);
      if (i == 4) begin
        entry(16'hFFF8, `NIP_PRIO_L1);
        ext_pin[0] <= 1'b0;
        repeat (8) @(posedge clk);
        cpu.return_from_irq(8'h20);
      end
      quiet(20);
    end
    $display("test external done");
  endtask : t_ext

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    rst_b <= 1'b0;
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
    paddr <= 8'h00;
    pwdata <= 32'h0000_0000;
    halt_mode <= 1'b0;
    ext_pin <= 12'hFFF;
    top_level_irq <= 1'b1;
    pflag <= 9'h000;
    pen <= 9'h000;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    #1;
    t_reset();
    t_regs();
    t_periph();
    t_nmi();
    t_ext();
    chk("stack order", cpu.seq_err, 0);
    tally_and_finish();
  end
  // Whole run needs well under a thousand cycles
  initial begin
    #400000;
    fail_count++;
    tally_and_finish();
  end
endmodule : nip_ctrl_tb
